// >>> bench/fdtr_ctrl_properties.sv
// port assertions for the fan threshold and ramp controller
`timescale 1ns/1ps
module fdtr_ctrl_checker #(
  parameter int unsigned RAMP_STEP_CYCLES = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // temperatures and duties
  input wire fdtr_pkg::fdtr_temps_t temps,
  input wire fdtr_pkg::fdtr_duty_t fan_duty
);
  import fdtr_pkg::*;
  logic [1:0] up_cnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // edges since release; the internal reset copy lags the pin by two edges
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) up_cnt <= 2'h0;
    else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
  end
  setup_gets_ready_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  upper_data_zero_a: assert property (prdata[31:8] == 24'h0)
    else $error("upper read data set");
  misaligned_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access accepted");
  unmapped_err_a: assert property (pready && paddr[9:2] == 8'h00 |-> pslverr)
    else $error("unmapped access accepted");
  reset_duty_zero_a: assert property ($rose(rstn) |-> fan_duty == '0)
    else $error("duty not zero after reset");
  hard_full_duty_a: assert property (
    up_cnt == 2'h3 && temps.temp[0] == 8'hFF |=> fan_duty.duty[0] == 8'hFF)
    else $error("hot channel not at full duty");
  // main scenarios
  cover property (psel && penable && pready && !pslverr);
  cover property (pready && pslverr);
  cover property (fan_duty.duty[0] == 8'hFF);
endmodule

bind fdtr_ctrl fdtr_ctrl_checker #(.RAMP_STEP_CYCLES(RAMP_STEP_CYCLES)) chk (
  .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .temps(temps),
  .fan_duty(fan_duty));

// >>> bench/fdtr_sensor_model.sv
// temperature sensor model: holds readings and gives the monitoring strobe
`timescale 1ns/1ps
module fdtr_sensor_model (
  // clock
  input wire logic core_clk,
  // readings to the controller
  output fdtr_pkg::fdtr_temps_t temps,
  output logic temp_valid
);
  import fdtr_pkg::*;
  initial begin
    temps = '0;
    temp_valid = 1'b0;
  end
  // new reading on one channel, changed just after an edge
  task automatic set_temp(input int ch, input logic [7:0] t);
    @(posedge core_clk);
    temps.temp[ch] <= t;
  endtask
  // one monitoring cycle: a single-cycle strobe
  task automatic strobe();
    @(posedge core_clk);
    temp_valid <= 1'b1;
    @(posedge core_clk);
    temp_valid <= 1'b0;
  endtask
endmodule

// >>> bench/tb_top.sv
// self-checking bench for the fan threshold and ramp controller
`timescale 1ns/1ps
module tb_top;
  import fdtr_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic temp_valid;
  fdtr_temps_t temps;
  fdtr_duty_t fan_duty;
  int num_errors = 0;
  int samples_checked = 0;
  int waited;
  logic [31:0] rd;
  logic err;
  logic [7:0] steps [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};

  always #2.5 core_clk = ~core_clk;

  fdtr_ctrl #(.RAMP_STEP_CYCLES(8)) uut (.core_clk(core_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .temps(temps), .temp_valid(temp_valid),
    .fan_duty(fan_duty));
  fdtr_sensor_model sensor (.core_clk(core_clk), .temps(temps), .temp_valid(temp_valid));

  task automatic end_sim();
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string w, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask

  // one transfer; the request stays put until pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [7:0] wd);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {24'h0, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    if (n >= 16) num_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {22'h0, idx, 2'b00}, d);
  endtask

  task automatic rdc(input string w, input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, {22'h0, idx, 2'b00}, 8'h00);
    check(w, rd[7:0], e);
  endtask

  // edges counted while a duty output keeps one value, bounded
  task automatic wait_while(input int ch, input logic [7:0] v, input int lim);
    waited = 0;
    while (fan_duty.duty[ch] === v && waited < lim) begin
      @(posedge core_clk);
      waited++;
    end
  endtask

  task automatic t_reset_values();
    for (int c = 0; c < 3; c++) begin
      rdc("op reset", IDX_R1_OP + 8'(c), RST_OP);
      rdc("hard reset", IDX_R1_HARD + 8'(c), RST_HARD);
    end
    rdc("hyst1 reset", IDX_HYST_1, {RST_HYST, RST_HYST});
    apb(1'b0, {22'h0, IDX_HYST_2, 2'b00}, 8'h00);
    check("hyst2 reset", rd[7:0] & 8'hF0, {RST_HYST, 4'h0});
    rdc("dyn ctrl reset", IDX_DYN_CTRL, RST_CTRL);
  endtask

  task automatic t_access();
    wr(IDX_R1_OP, 8'h64);
    rdc("op rw", IDX_R1_OP, 8'h64);
    wr(IDX_HYST_1, 8'hF1);
    rdc("hyst rw", IDX_HYST_1, 8'hF1);
    wr(IDX_HYST_1, 8'h44);
    apb(1'b0, 32'h0, 8'h00);
    check("unmapped err", {7'h00, err}, 8'h01);
    apb(1'b1, {22'h0, IDX_R2_OP, 2'b01}, 8'h11);
    check("misaligned err", {7'h00, err}, 8'h01);
    rdc("misaligned no write", IDX_R2_OP, RST_OP);
  endtask

  // duty at the edge of the slope, then the hard limit taking over
  task automatic t_full_speed();
    sensor.set_temp(0, 8'h71);
    repeat (3) @(posedge core_clk);
    check("slope duty", fan_duty.duty[0], 8'hFA);
    sensor.set_temp(0, 8'h72);
    repeat (3) @(posedge core_clk);
    check("slope full", fan_duty.duty[0], 8'hFF);
    wr(IDX_R1_HARD, 8'h50);
    sensor.set_temp(0, 8'h4F);
    repeat (3) @(posedge core_clk);
    check("below hard", fan_duty.duty[0], 8'h00);
    sensor.set_temp(0, 8'h50);
    repeat (3) @(posedge core_clk);
    check("at hard", fan_duty.duty[0], 8'hFF);
    sensor.set_temp(0, 8'hFF);
    wr(IDX_R1_HARD, RST_HARD);
  endtask

  // op is 0x64 and hysteresis 4, so the drop region starts above 0x60
  task automatic t_dynamic();
    wr(IDX_DYN_CTRL, 8'h20);
    wr(IDX_LOW_BASE, 8'h70);
    sensor.set_temp(0, 8'h40);
    sensor.strobe();
    rdc("thr hold", IDX_THR_BASE, 8'h5A);
    sensor.set_temp(0, 8'h60);
    repeat (3) sensor.strobe();
    rdc("thr raise", IDX_THR_BASE, 8'h5D);
    wr(IDX_HIGH_BASE, 8'h5C);
    sensor.strobe();
    rdc("thr clamp", IDX_THR_BASE, 8'h5C);
    sensor.set_temp(0, 8'h61);
    sensor.strobe();
    rdc("thr drop", IDX_THR_BASE, 8'h5A);
    wr(IDX_DYN_RATE, 8'h01);
    sensor.set_temp(0, 8'h62);
    sensor.strobe();
    rdc("thr drop rate", IDX_THR_BASE, 8'h56);
    // writing the programmed value reloads channel 0 so each channel starts at 0x5A
    wr(IDX_TMIN_BASE, 8'h5A);
    for (int c = 0; c < 3; c++) begin
      wr(IDX_LOW_BASE + 8'(c), 8'h70);
      wr(IDX_DYN_CTRL, 8'h20 << c);
      sensor.set_temp(c, 8'h60);
      sensor.strobe();
      rdc("enable bit", IDX_THR_BASE + 8'(c), 8'h5B);
    end
    wr(IDX_DYN_CTRL, 8'h00);
    sensor.strobe();
    rdc("thr fixed", IDX_THR_BASE, 8'h5A);
    rdc("thr fixed ch2", IDX_THR_BASE + 8'h02, 8'h5A);
    for (int c = 0; c < 3; c++) sensor.set_temp(c, 8'h00);
  endtask

  // ramp from zero to the 0x80 target and back down
  task automatic t_ramp(input int ch, input logic [7:0] idx, input logic [7:0] cfg,
                        input logic [7:0] step);
    wr(idx, cfg);
    sensor.set_temp(ch, 8'h5A);
    wait_while(ch, 8'h00, 40);
    check("first step", fan_duty.duty[ch], step);
    wait_while(ch, step, 40);
    check("step spacing", 8'(waited), 8'h08);
    check("second step", fan_duty.duty[ch], 8'(2 * step));
    waited = 0;
    while (fan_duty.duty[ch] !== 8'h80 && waited < 3000) begin
      @(posedge core_clk);
      waited++;
    end
    check("ramp lands", fan_duty.duty[ch], 8'h80);
    sensor.set_temp(ch, 8'h00);
    wait_while(ch, 8'h80, 40);
    check("ramp down", fan_duty.duty[ch], 8'h80 - step);
    wr(idx, 8'h00);
    repeat (2) @(posedge core_clk);
    check("ramp off", fan_duty.duty[ch], 8'h00);
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset_values();
    t_access();
    t_full_speed();
    t_dynamic();
    for (int c = 0; c < 8; c++) t_ramp(0, IDX_OUT1_RAMP_RATE_1, {5'h01, 3'(c)}, steps[c]);
    t_ramp(1, IDX_OUT1_RAMP_RATE_2, 8'hF0, 8'h30);
    t_ramp(2, IDX_OUT1_RAMP_RATE_2, 8'h0D, 8'h0C);
    end_sim();
  end

  // watchdog: the whole run needs well under this many cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    end_sim();
  end
endmodule

// >>> hdl/fdtr_ctrl.sv
// dynamic fan-on threshold and ramp-limited duty controller with apb register file
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module fdtr_ctrl #(
  parameter int unsigned RAMP_STEP_CYCLES = 32'(fdtr_pkg::RAMP_STEP_CYCLES_DEF)
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // temperature readings from the monitor, same clock
  input wire fdtr_pkg::fdtr_temps_t temps,
  input wire logic temp_valid,
  // duty targets to fan_out_1..3 drivers
  output fdtr_pkg::fdtr_duty_t fan_duty
);
  import fdtr_pkg::*;

  fdtr_state_t st_reg;
  fdtr_state_t st_next;
  logic [1:0] rst_sync_reg;
  logic rst_n_int;

  // reset released through two flops so all state leaves reset on one edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_reg[1];

  // ramp code to step size in time slots
  function automatic logic [7:0] step_of(input logic [2:0] code);
    case (code) // [R11] [R12]
      3'h0: step_of = 8'h01;
      3'h1: step_of = 8'h02;
      3'h2: step_of = 8'h03;
      3'h3: step_of = 8'h05;
      3'h4: step_of = 8'h08;
      3'h5: step_of = 8'h0C;
      3'h6: step_of = 8'h18;
      default: step_of = 8'h30;
    endcase
  endfunction

  // duty from temperature along the programmed slope
  function automatic logic [7:0] calc_duty(input logic [7:0] t, input logic [7:0] thr,
                                           input logic [7:0] pmin, input logic [7:0] rng,
                                           input logic [7:0] hard);
    logic [15:0] rise;
    logic [15:0] sum;
    rise = 16'h0000;
    sum = 16'h0000;
    if (t >= hard) begin
      calc_duty = DUTY_FULL; // [R14]
    end else if (t < thr) begin
      calc_duty = 8'h00;
    end else if (rng == 8'h00) begin
      calc_duty = DUTY_FULL;
    end else begin
      // slope of 170 duty codes per range degrees gives the full-speed point
      rise = ({8'h00, t} - {8'h00, thr}) * SLOPE_NUM / {8'h00, rng}; // [R15]
      sum = rise + {8'h00, pmin};
      calc_duty = (sum > {8'h00, DUTY_FULL}) ? DUTY_FULL : sum[7:0];
    end
  endfunction

  // one ramp step toward the target, never past it
  function automatic logic [7:0] ramp_step(input logic [7:0] prev, input logic [7:0] tgt,
                                           input logic [7:0] step);
    if (tgt > prev) begin
      ramp_step = ((tgt - prev) < step) ? tgt : prev + step; // [R17] [R18]
    end else if (tgt < prev) begin
      ramp_step = ((prev - tgt) < step) ? tgt : prev - step; // [R17] [R18]
    end else begin
      ramp_step = prev;
    end
  endfunction

  // register read mux; unknown indices read zero and are flagged by the caller
  function automatic logic [7:0] rd_reg(input fdtr_state_t s, input logic [7:0] idx);
    rd_reg = 8'h00;
    case (idx)
      IDX_R1_OP: rd_reg = s.op[0];
      IDX_LO_OP: rd_reg = s.op[1];
      IDX_R2_OP: rd_reg = s.op[2];
      IDX_DYN_CTRL: rd_reg = s.dyn_ctrl;
      IDX_OUT1_RAMP_RATE_1: rd_reg = s.acou1;
      IDX_OUT1_RAMP_RATE_2: rd_reg = s.out2_ramp_rate;
      IDX_R1_HARD: rd_reg = s.hard[0];
      IDX_LO_HARD: rd_reg = s.hard[1];
      IDX_R2_HARD: rd_reg = s.hard[2];
      IDX_HYST_1: rd_reg = {s.hyst[0], s.hyst[1]};
      IDX_HYST_2: rd_reg = {s.hyst[2], 4'h0};
      IDX_RANGE: rd_reg = s.range;
      IDX_DYN_RATE: rd_reg = s.rate;
      default: begin
        for (int c = 0; c < 3; c++) begin
          if (idx == IDX_TMIN_BASE + 8'(c)) rd_reg = s.tmin[c];
          if (idx == IDX_LOW_BASE + 8'(c)) rd_reg = s.low[c];
          if (idx == IDX_HIGH_BASE + 8'(c)) rd_reg = s.high[c];
          if (idx == IDX_PMIN_BASE + 8'(c)) rd_reg = s.pmin[c];
          if (idx == IDX_THR_BASE + 8'(c)) rd_reg = s.thr[c];
          if (idx == IDX_DUTY_BASE + 8'(c)) rd_reg = s.duty[c];
        end
      end
    endcase
  endfunction

  // address decode shared by read and write paths
  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx >= IDX_R1_OP && idx <= IDX_DYN_CTRL) ||
                (idx == IDX_OUT1_RAMP_RATE_1) || (idx == IDX_OUT1_RAMP_RATE_2) ||
                (idx >= IDX_R1_HARD && idx <= IDX_HYST_2) ||
                (idx >= IDX_TMIN_BASE && idx <= IDX_DYN_RATE) ||
                (idx >= IDX_THR_BASE && idx <= IDX_DUTY_BASE + 8'h02);
  endfunction

  logic [7:0] bus_idx;
  logic bus_ok;
  logic tick;
  logic [2:0] ramp_en;
  logic [2:0][2:0] ramp_code;
  logic [2:0][7:0] target;
  logic [2:0][7:0] op_low;
  logic [2:0][15:0] drop;
  logic [2:0][7:0] new_thr;

  assign bus_idx = paddr[9:2];
  assign bus_ok = is_mapped(bus_idx) && (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h000000);
  assign tick = (st_reg.tick_cnt == TICK_W'(RAMP_STEP_CYCLES - 1));
  assign ramp_en = {st_reg.out2_ramp_rate[RAMP_EN_BIT_LO], st_reg.out2_ramp_rate[RAMP_EN_BIT_HI],
                    st_reg.acou1[RAMP_EN_BIT_LO]}; // [R16]
  assign ramp_code[0] = st_reg.acou1[RATE_LO_LSB +: 3]; // [R11]
  assign ramp_code[1] = st_reg.out2_ramp_rate[RATE_HI_LSB +: 3]; // [R12]
  assign ramp_code[2] = st_reg.out2_ramp_rate[RATE_LO_LSB +: 3]; // [R12]

  // per channel: threshold arithmetic and duty target; out n follows channel n
  for (genvar c = 0; c < 3; c++) begin : g_chan
    logic [7:0] rise;
    // zero hysteresis simply removes the margin below the operating point
    assign op_low[c] = (st_reg.op[c] > {4'h0, st_reg.hyst[c]}) ?
                       st_reg.op[c] - {4'h0, st_reg.hyst[c]} : 8'h00; // [R03]
    assign rise = (temps.temp[c] > st_reg.last[c]) ? temps.temp[c] - st_reg.last[c] : 8'h00;
    // one degree of rise gives two degrees of drop at rate zero, doubling per rate step
    assign drop[c] = ({8'h00, rise} << 1) << st_reg.rate[1:0]; // [R06]
    always_comb begin
      new_thr[c] = st_reg.thr[c];
      if (temps.temp[c] > op_low[c]) begin
        new_thr[c] = ({8'h00, st_reg.thr[c]} > drop[c]) ?
                     st_reg.thr[c] - drop[c][7:0] : 8'h00; // [R06]
      end else if (temps.temp[c] > st_reg.thr[c] && temps.temp[c] < st_reg.low[c] &&
                   st_reg.thr[c] < st_reg.high[c] && st_reg.thr[c] < st_reg.op[c]) begin
        new_thr[c] = st_reg.thr[c] + 8'h01; // [R08] [R09]
      end
      // below op - hyst and outside the rise window the threshold holds [R05]
      if (new_thr[c] > st_reg.high[c]) begin
        new_thr[c] = st_reg.high[c]; // [R07]
      end
    end
    assign target[c] = calc_duty(temps.temp[c], st_reg.thr[c], st_reg.pmin[c],
                                 st_reg.range, st_reg.hard[c]);
  end

  // next-state logic: bus slave, threshold tracking, ramp limiter
  always_comb begin
    st_next = st_reg;
    // apb: answer one cycle after setup, write lands on the completing edge
    case (st_reg.ph)
      FDTR_IDLE: begin
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        if (psel && !penable) begin
          st_next.ph = FDTR_ACCESS;
          st_next.pready = 1'b1;
          st_next.pslverr = !bus_ok;
          st_next.prdata = (!pwrite && bus_ok) ? {24'h000000, rd_reg(st_reg, bus_idx)} :
                           32'h00000000;
        end
      end
      FDTR_ACCESS: begin
        // read data stands for the access cycle only, so idle reads show zero
        st_next.ph = FDTR_IDLE;
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        st_next.prdata = 32'h00000000;
      end
      default: begin
        st_next.ph = FDTR_IDLE;
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        st_next.prdata = 32'h00000000;
      end
    endcase

    // monitoring cycle: threshold update per enabled channel, reload from tmin per disabled one
    if (temp_valid) begin
      for (int c = 0; c < 3; c++) begin
        if (st_reg.dyn_ctrl[DYN_EN_LSB + c]) begin
          st_next.thr[c] = new_thr[c]; // [R10]
        end else begin
          st_next.thr[c] = st_reg.tmin[c]; // [R10]
        end
        st_next.last[c] = temps.temp[c];
      end
    end

    // ramp tick counter sets the 35 s full-swing pace at one slot per step
    st_next.tick_cnt = tick ? '0 : st_reg.tick_cnt + TICK_W'(1); // [R13]
    for (int c = 0; c < 3; c++) begin
      if (temps.temp[c] >= st_reg.hard[c]) begin
        // fail-safe: hard limit bypasses the ramp limiter
        st_next.duty[c] = DUTY_FULL; // [R14]
      end else if (!ramp_en[c]) begin
        st_next.duty[c] = target[c];
      end else if (tick) begin
        st_next.duty[c] = ramp_step(st_reg.duty[c], target[c],
                                    step_of(ramp_code[c])); // [R17]
      end
    end

    // register writes, applied at the access edge; read-only indices ignore data
    if (st_reg.ph == FDTR_ACCESS && psel && penable && pwrite && bus_ok) begin
      case (bus_idx)
        IDX_R1_OP: st_next.op[0] = pwdata[7:0]; // [R04]
        IDX_LO_OP: st_next.op[1] = pwdata[7:0]; // [R04]
        IDX_R2_OP: st_next.op[2] = pwdata[7:0]; // [R04]
        IDX_DYN_CTRL: st_next.dyn_ctrl = pwdata[7:0];
        IDX_OUT1_RAMP_RATE_1: st_next.acou1 = pwdata[7:0];
        IDX_OUT1_RAMP_RATE_2: st_next.out2_ramp_rate = pwdata[7:0];
        IDX_R1_HARD: st_next.hard[0] = pwdata[7:0]; // [R01]
        IDX_LO_HARD: st_next.hard[1] = pwdata[7:0]; // [R01]
        IDX_R2_HARD: st_next.hard[2] = pwdata[7:0]; // [R01]
        IDX_HYST_1: begin
          st_next.hyst[0] = pwdata[7:4]; // [R02]
          st_next.hyst[1] = pwdata[3:0]; // [R02]
        end
        IDX_HYST_2: st_next.hyst[2] = pwdata[7:4]; // [R02]
        IDX_RANGE: st_next.range = pwdata[7:0];
        IDX_DYN_RATE: st_next.rate = pwdata[7:0];
        default: begin
          for (int c = 0; c < 3; c++) begin
            if (bus_idx == IDX_TMIN_BASE + 8'(c)) begin
              st_next.tmin[c] = pwdata[7:0];
              st_next.thr[c] = pwdata[7:0]; // programmed value restarts tracking
            end
            if (bus_idx == IDX_LOW_BASE + 8'(c)) st_next.low[c] = pwdata[7:0];
            if (bus_idx == IDX_HIGH_BASE + 8'(c)) st_next.high[c] = pwdata[7:0];
            if (bus_idx == IDX_PMIN_BASE + 8'(c)) st_next.pmin[c] = pwdata[7:0];
          end
        end
      endcase
    end
  end

  // state register; reset values are all constants
  always_ff @(posedge core_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      st_reg.ph <= FDTR_IDLE;
      st_reg.pready <= 1'b0;
      st_reg.pslverr <= 1'b0;
      st_reg.prdata <= 32'h00000000;
      st_reg.op <= {3{RST_OP}}; // [R04]
      st_reg.hard <= {3{RST_HARD}}; // [R01]
      st_reg.hyst <= {3{RST_HYST}}; // [R02]
      st_reg.dyn_ctrl <= RST_CTRL;
      st_reg.acou1 <= RST_CTRL;
      st_reg.out2_ramp_rate <= RST_CTRL;
      st_reg.tmin <= {3{RST_TMIN}};
      st_reg.low <= {3{RST_LOW}};
      st_reg.high <= {3{RST_HIGH}};
      st_reg.pmin <= {3{RST_PMIN}};
      st_reg.range <= RST_RANGE;
      st_reg.rate <= RST_CTRL;
      st_reg.thr <= {3{RST_TMIN}};
      st_reg.last <= '0;
      st_reg.duty <= '0;
      st_reg.tick_cnt <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign fan_duty.duty = st_reg.duty;

endmodule

// >>> inc/fdtr_pkg.sv
// constants, register map and carrier types for the fan threshold and ramp controller
// How it works
// R01: three 8-bit hard-limit registers, reset to the 100 degree code 0xA4.
// R02: hysteresis nibbles: remote1 7:4, local 3:0, remote2 7:4 of second register.
// R03: hysteresis 1..15 degrees; zero disables it, software should avoid zero.
// R04: three 8-bit operating-point registers, one degree steps, reset 0xA4.
// R05: threshold unchanged while temperature is below operating point minus hysteresis.
// R06: above that, threshold drops each cycle; one degree rise drops two, scaled by rate.
// R07: adjusted threshold never exceeds the channel's high limit.
// R08: threshold rises only if above it, below low, below high and operating point.
// R09: threshold is never raised above the operating point.
// R10: dynamic control enable bits 5, 6, 7; zero keeps the programmed threshold.
// R11: output 1 ramp code bits 2:0 picks 1,2,3,5,8,12,24,48 slots.
// R12: output 2 ramp code bits 6:4, output 3 bits 2:0 of second register.
// R13: full 0..100 percent swing about 35 s at one slot, 0.8 s at 48.
// R14: temperature at hard limit forces the associated fan to full duty.
// R15: full-speed temp is threshold plus (255 - minimum) times range over 170.
// R16: ramp enable bit 3 of first register, bits 7 and 3 of the second.
// R17: each update steps the previous duty toward target and stores it back.
// R18: a step larger than the remaining gap lands exactly on the target.
package fdtr_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_R1_OP = 8'h33;
  localparam logic [7:0] IDX_LO_OP = 8'h34;
  localparam logic [7:0] IDX_R2_OP = 8'h35;
  localparam logic [7:0] IDX_DYN_CTRL = 8'h36;
  localparam logic [7:0] IDX_OUT1_RAMP_RATE_1 = 8'h62;
  localparam logic [7:0] IDX_OUT1_RAMP_RATE_2 = 8'h63;
  localparam logic [7:0] IDX_R1_HARD = 8'h6A;
  localparam logic [7:0] IDX_LO_HARD = 8'h6B;
  localparam logic [7:0] IDX_R2_HARD = 8'h6C;
  localparam logic [7:0] IDX_HYST_1 = 8'h6D;
  localparam logic [7:0] IDX_HYST_2 = 8'h6E;
  // per-channel blocks of three, base index + channel; range and rate are single registers
  localparam logic [7:0] IDX_TMIN_BASE = 8'h80;
  localparam logic [7:0] IDX_LOW_BASE = 8'h83;
  localparam logic [7:0] IDX_HIGH_BASE = 8'h86;
  localparam logic [7:0] IDX_PMIN_BASE = 8'h89;
  localparam logic [7:0] IDX_RANGE = 8'h8C;
  localparam logic [7:0] IDX_DYN_RATE = 8'h8D;
  localparam logic [7:0] IDX_THR_BASE = 8'h90;
  localparam logic [7:0] IDX_DUTY_BASE = 8'h93;

  // reset values
  localparam logic [7:0] RST_OP = 8'hA4;
  localparam logic [7:0] RST_HARD = 8'hA4;
  localparam logic [3:0] RST_HYST = 4'h4;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_TMIN = 8'h5A;
  localparam logic [7:0] RST_LOW = 8'h50;
  localparam logic [7:0] RST_HIGH = 8'h6E;
  localparam logic [7:0] RST_PMIN = 8'h80;
  localparam logic [7:0] RST_RANGE = 8'h20;

  // field positions
  localparam int DYN_EN_LSB = 5;
  localparam int RAMP_EN_BIT_LO = 3;
  localparam int RAMP_EN_BIT_HI = 7;
  localparam int RATE_LO_LSB = 0;
  localparam int RATE_HI_LSB = 4;

  // duty arithmetic
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [15:0] SLOPE_NUM = 16'h00AA;

  // ramp timing: 255 one-slot steps span the full swing
  localparam longint unsigned CLK_HZ = 64'd200000000;
  localparam longint unsigned RAMP_SWING_MS = 64'd35000;
  localparam longint unsigned DUTY_SLOTS = 64'd255;
  localparam longint unsigned RAMP_STEP_CYCLES_DEF =
    (CLK_HZ / 64'd1000) * RAMP_SWING_MS / DUTY_SLOTS;
  localparam int TICK_W = 25;

  // apb phase
  typedef enum logic {FDTR_IDLE = 1'b0, FDTR_ACCESS = 1'b1} fdtr_phase_t;

  typedef struct packed {
    logic [2:0][7:0] temp;
  } fdtr_temps_t;

  typedef struct packed {
    logic [2:0][7:0] duty;
  } fdtr_duty_t;

  typedef struct packed {
    fdtr_phase_t ph;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [2:0][7:0] op;
    logic [2:0][7:0] hard;
    logic [2:0][3:0] hyst;
    logic [7:0] dyn_ctrl;
    logic [7:0] acou1;
    logic [7:0] out2_ramp_rate;
    logic [2:0][7:0] tmin;
    logic [2:0][7:0] low;
    logic [2:0][7:0] high;
    logic [2:0][7:0] pmin;
    logic [7:0] range;
    logic [7:0] rate;
    logic [2:0][7:0] thr;
    logic [2:0][7:0] last;
    logic [2:0][7:0] duty;
    logic [TICK_W-1:0] tick_cnt;
  } fdtr_state_t;

endpackage
